// file: pmr_device.sv
// Power mode sequencer, reset logic and serial register port of the transceiver.
// Assumes comparator, oscillator and wake inputs are asynchronous to clk.
`timescale 1ns/10ps

// Notes on behaviour
// R1 - Low auxiliary supply: stay OFF, serial ignored
// R2 - Auxiliary detect in OFF enters auxiliary mode
// R3 - OFF to auxiliary raises interrupt, aux flag
// R4 - Wake pin or button: OFF to Idle, flag
// R5 - Aux to Idle by enable, pin, button
// R6 - Idle powers analog and core from battery
// R7 - Idle accepts writes and selects RF mode
// R8 - OFF command only with all wakes released
// R9 - Power-up issues core reset, loads defaults
// R10 - Host reset low until supply high, oscillator
// R11 - Host clock after supply good, oscillator ready
// R12 - Low flag clears on read or reset
// R13 - Supply loss: reset host, core if enabled
// R14 - Supply below lower: clock low, serial ignored
// R15 - Supply output off until reactivation
// R16 - Status register separate, serially readable
// R17 - Control registers default after power-on
// R18 - Synchronise comparators and oscillator ready
// R19 - Host reset is set-reset latch, hysteresis
module pmr_device
   import pmr_pkg::*;
(
   // Clock and reset
   input  wire logic                       clk,
   input  wire logic                       srst,
   // Link to host
   pmr_link_if.device                      link,
   // Wake pins
   input  wire logic                       wakePinHigh,
   input  wire logic [pmr_pkg::PMR_BTN_NUM-1:0] pushButtonN,
   // Comparators and oscillator
   input  wire logic                       auxSupplyDetect,
   input  wire logic                       supplyOutGood,
   input  wire logic                       supplyOutHigh,
   input  wire logic                       oscReady,
   // Supply and mode controls
   output pmr_pkg::pmr_mode_t              mode,
   output logic                            analogSupplyOn,
   output logic                            coreSupplyOn,
   output logic                            coreFromAux,
   output logic                            supplyOutOn,
   output logic                            coreReset,
   output logic [1:0]                      rfOpMode,
   output logic                            lowSupplyFlag
);
   import pmr_pkg::*;

   typedef struct packed {
      logic [1:0]                    csS;
      logic [1:0]                    sckS;
      logic [1:0]                    sdiS;
      logic [1:0]                    auxS;
      logic [1:0]                    goodS;
      logic [1:0]                    highS;
      logic [1:0]                    oscS;
      logic [1:0]                    wakeS;
      logic [1:0][PMR_BTN_NUM-1:0]   btnS;
      logic                          sckPrev;
      logic                          goodPrev;
      pmr_mode_t                     mode;
      logic [PMR_CTRL_NUM-1:0][7:0]  ctrl;
      logic [7:0]                    status;
      logic [4:0]                    bitCnt;
      logic [7:0]                    cmd;
      logic [7:0]                    data;
      logic [7:0]                    shOut;
      logic                          sdo;
      logic                          hostRstN;
      logic                          coreRst;
      logic [1:0]                    clkDiv;
      logic                          hostClk;
      logic                          stRead;
   } pmr_dev_state_t;

   // Synchronisers start at the idle pin levels so that reset cannot fake a wake
   localparam pmr_dev_state_t DEV_RESET = '{mode: PMR_OFF, csS: 2'h3, btnS: '1, default: '0};

   pmr_dev_state_t s;
   pmr_dev_state_t next_s;

   function automatic logic [7:0] ctrlRead(input logic [PMR_CTRL_NUM-1:0][7:0] regs,
                                           input logic [2:0] adr);
      ctrlRead = (int'(adr) < PMR_CTRL_NUM) ? regs[adr] : 8'h00;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      logic                   wakeHi;
      logic [PMR_BTN_NUM-1:0] btnLow;
      logic                   anyWake;
      logic                   good;
      logic                   serialOk;
      logic                   sckRise;
      logic                   sckFall;
      logic                   offReq;
      logic [7:0]             cmdNow;
      wakeHi   = '0;
      btnLow   = '0;
      anyWake  = '0;
      good     = '0;
      serialOk = '0;
      sckRise  = '0;
      sckFall  = '0;
      offReq   = '0;
      cmdNow   = '0;
      next_s   = s;

      // Two flops on every pin and comparator before use
      next_s.csS   = {s.csS[0], link.csN};
      next_s.sckS  = {s.sckS[0], link.sck};
      next_s.sdiS  = {s.sdiS[0], link.sdi};
      next_s.auxS  = {s.auxS[0], auxSupplyDetect};                         // R18
      next_s.goodS = {s.goodS[0], supplyOutGood};                          // R18
      next_s.highS = {s.highS[0], supplyOutHigh};                          // R18
      next_s.oscS  = {s.oscS[0], oscReady};                                // R18
      next_s.wakeS = {s.wakeS[0], wakePinHigh};
      next_s.btnS  = {s.btnS[0], pushButtonN};
      next_s.sckPrev  = s.sckS[1];
      next_s.goodPrev = s.goodS[1];
      next_s.coreRst  = 1'b0;

      wakeHi   = s.wakeS[1];
      btnLow   = ~s.btnS[1];
      anyWake  = wakeHi | (|btnLow);
      good     = s.goodS[1];
      serialOk = (s.mode != PMR_OFF) && good;                              // R1 R14
      sckRise  = s.sckS[1] & ~s.sckPrev;
      sckFall  = ~s.sckS[1] & s.sckPrev;
      cmdNow   = {s.cmd[6:0], s.sdiS[1]};

      ////////////////////////////////////////////////////////////////////////
      // Serial port
      if (!serialOk || s.csS[1]) begin
         next_s.bitCnt = '0;
         next_s.sdo    = 1'b0;
         if (s.stRead && s.csS[1]) begin
            // Reading status clears wake flags; low flag only with supply back
            next_s.stRead = 1'b0;
            next_s.status[7:PMR_ST_WAKEPIN] = '0;
            next_s.status[PMR_ST_AUX] = 1'b0;
            if (s.highS[1]) begin
               next_s.status[PMR_ST_LOWBAT] = 1'b0;                        // R12
            end
         end
      end else begin
         if (sckRise) begin
            next_s.bitCnt = s.bitCnt + 5'h01;
            if (s.bitCnt < 5'h08) begin
               next_s.cmd = cmdNow;
            end else begin
               next_s.data = {s.data[6:0], s.sdiS[1]};
            end
            if (s.bitCnt == 5'h07) begin
               unique case (cmdNow[7:6])
                  PMR_CMD_WRITE: begin
                  end
                  PMR_CMD_RD_CTRL: begin
                     next_s.shOut = ctrlRead(s.ctrl, cmdNow[2:0]);
                  end
                  PMR_CMD_RD_STAT: begin
                     next_s.shOut  = s.status;                             // R16
                     next_s.stRead = 1'b1;
                  end
                  PMR_CMD_OFF: begin
                     // Refused while any wake source still asks for power
                     offReq = !s.ctrl[PMR_ADR_CTRL1][PMR_C1_ANALOG_EN]
                              && !anyWake;                                 // R8
                  end
               endcase
            end
            if (s.bitCnt == 5'h0F && s.cmd[7:6] == PMR_CMD_WRITE
                && int'(s.cmd[2:0]) < PMR_CTRL_NUM) begin
               next_s.ctrl[s.cmd[2:0]] = {s.data[6:0], s.sdiS[1]};         // R7
            end
         end
         if (sckFall && s.bitCnt >= 5'h08) begin
            next_s.sdo   = s.shOut[7];
            next_s.shOut = {s.shOut[6:0], 1'b0};
         end
      end

      ////////////////////////////////////////////////////////////////////////
      // Supply output reactivation and supply loss
      if (s.mode != PMR_OFF && anyWake) begin
         next_s.ctrl[PMR_ADR_CTRL3][PMR_C3_SUPPLY_EN] = 1'b1;              // R15
      end
      if (s.mode != PMR_OFF && s.goodPrev && !good
          && s.ctrl[PMR_ADR_CTRL3][PMR_C3_SUPPLY_EN]) begin
         next_s.ctrl    = PMR_CTRL_DEFAULT;                                // R13
         next_s.coreRst = 1'b1;                                            // R13
      end
      if (s.mode != PMR_OFF && !s.highS[1]) begin
         next_s.status[PMR_ST_LOWBAT] = 1'b1;                              // R12
      end else if (s.mode != PMR_OFF && s.highS[1] && !s.hostRstN) begin
         next_s.status[PMR_ST_LOWBAT] = 1'b0;                              // R12
      end

      ////////////////////////////////////////////////////////////////////////
      // Mode sequencer
      unique case (s.mode)
         PMR_OFF: begin
            // Nothing survives OFF; entry starts from defaults
            next_s.status = '0;
            next_s.ctrl   = PMR_CTRL_DEFAULT;                              // R17
            if (anyWake) begin
               next_s.mode    = PMR_IDLE;                                  // R4
               next_s.coreRst = 1'b1;                                      // R9
               next_s.status[PMR_ST_WAKEPIN] = wakeHi;                     // R4
               next_s.status[PMR_ST_BTN_LSB +: PMR_BTN_NUM] = btnLow;      // R4
            end else if (s.auxS[1]) begin
               next_s.mode    = PMR_AUX;                                   // R2
               next_s.coreRst = 1'b1;                                      // R9
               next_s.status[PMR_ST_AUX] = 1'b1;                           // R3
            end
         end
         PMR_AUX: begin
            if (offReq) begin
               next_s.mode = PMR_OFF;
            end else if (anyWake || s.ctrl[PMR_ADR_CTRL1][PMR_C1_ANALOG_EN]) begin
               next_s.mode = PMR_IDLE;                                     // R5
            end
         end
         PMR_IDLE: begin
            if (offReq) begin
               next_s.mode = PMR_OFF;                                      // R8
            end
         end
      endcase

      ////////////////////////////////////////////////////////////////////////
      // Host reset latch: low below lower threshold, high only at upper
      if (s.mode == PMR_OFF || !good) begin
         next_s.hostRstN = 1'b0;                                           // R13 R19
      end else if (s.highS[1] && s.oscS[1]) begin
         next_s.hostRstN = 1'b1;                                           // R10 R19
      end

      // Host clock is clk/3 at one third duty; disable may cut the last period
      if (s.mode != PMR_OFF && good && s.oscS[1]
          && s.ctrl[PMR_ADR_CTRL3][PMR_C3_CLK_ON]) begin
         next_s.clkDiv  = (s.clkDiv == PMR_HCLK_DIV_LAST) ? 2'h0 : s.clkDiv + 2'h1;
         next_s.hostClk = (s.clkDiv == PMR_HCLK_DIV_LAST);                 // R11
      end else begin
         next_s.clkDiv  = 2'h0;
         next_s.hostClk = 1'b0;                                            // R14
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         s <= DEV_RESET;
      end else begin
         s <= next_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   assign link.sdo        = s.sdo;
   assign link.hostResetN = s.hostRstN;
   assign link.hostClk    = s.hostClk;
   assign link.irq        = (|s.status[7:PMR_ST_WAKEPIN]) | s.status[PMR_ST_AUX];   // R3 R4
   assign mode            = s.mode;
   assign analogSupplyOn  = (s.mode == PMR_IDLE);                          // R6
   assign coreSupplyOn    = (s.mode != PMR_OFF);                           // R1
   assign coreFromAux     = (s.mode == PMR_AUX);                           // R2
   assign supplyOutOn     = (s.mode != PMR_OFF)
                            && s.ctrl[PMR_ADR_CTRL3][PMR_C3_SUPPLY_EN];    // R15
   assign coreReset       = s.coreRst;
   assign rfOpMode        = (s.mode == PMR_IDLE)
                            ? s.ctrl[PMR_ADR_CTRL1][PMR_C1_OPM_LO +: 2] : 2'h0;     // R2 R7
   assign lowSupplyFlag   = s.status[PMR_ST_LOWBAT];

endmodule // pmr_device

// file: pmr_pkg.sv
// Shared constants and types of the power mode and reset control block.
// Assumes both ends and the bench compile this package first.
package pmr_pkg;

   typedef enum logic [1:0] {PMR_OFF, PMR_AUX, PMR_IDLE} pmr_mode_t;

   ////////////////////////////////////////////////////////////////////////////
   // Device control registers
   localparam int        PMR_CTRL_NUM     = 6;
   localparam logic [2:0] PMR_ADR_CTRL1   = 3'h0;
   localparam logic [2:0] PMR_ADR_CTRL3   = 3'h2;
   localparam int        PMR_C1_ANALOG_EN = 5;
   localparam int        PMR_C1_OPM_LO    = 1;
   localparam int        PMR_C3_SUPPLY_EN = 1;
   localparam int        PMR_C3_CLK_ON    = 0;
   localparam logic [5:0][7:0] PMR_CTRL_DEFAULT = {8'h00, 8'h00, 8'h00, 8'h03, 8'hB0, 8'h80};

   // Status register bits
   localparam int PMR_ST_AUX     = 0;
   localparam int PMR_ST_LOWBAT  = 1;
   localparam int PMR_ST_WAKEPIN = 2;
   localparam int PMR_ST_BTN_LSB = 3;
   localparam int PMR_BTN_NUM    = 5;

   ////////////////////////////////////////////////////////////////////////////
   // Serial frame: command byte then data byte, MSB first
   localparam int         PMR_FRAME_BITS  = 16;
   localparam logic [1:0] PMR_CMD_WRITE   = 2'h0;
   localparam logic [1:0] PMR_CMD_RD_CTRL = 2'h1;
   localparam logic [1:0] PMR_CMD_RD_STAT = 2'h2;
   localparam logic [1:0] PMR_CMD_OFF     = 2'h3;

   // Timing
   localparam int PMR_CLK_PERIOD_NS = 5;
   localparam int PMR_SCK_HALF_NS   = 1000;
   localparam int PMR_SCK_HALF_CYC  = (PMR_SCK_HALF_NS + PMR_CLK_PERIOD_NS - 1)
                                      / PMR_CLK_PERIOD_NS;
   localparam int PMR_SCK_HALF_MIN  = 8;
   localparam logic [1:0] PMR_HCLK_DIV_LAST = 2'h2;

   ////////////////////////////////////////////////////////////////////////////
   // Host controller APB registers
   localparam logic [11:0] PMR_H_CMD_OFF  = 12'h000;
   localparam logic [11:0] PMR_H_STAT_OFF = 12'h004;
   localparam logic [11:0] PMR_H_INT_OFF  = 12'h008;
   localparam logic [11:0] PMR_H_MASK_OFF = 12'h00C;
   localparam int PMR_HI_DONE    = 0;
   localparam int PMR_HI_DEVIRQ  = 1;
   localparam int PMR_HI_RSTFALL = 2;
   localparam int PMR_HS_BUSY    = 0;
   localparam int PMR_HS_RST_N   = 1;
   localparam int PMR_HS_IRQ     = 2;
   localparam int PMR_HS_RD_LSB  = 8;

endpackage

// file: pmr_link_if.sv
// Serial, reset, interrupt and clock pins between transceiver and host.
// Assumes one device end and one host end, joined by the bench.
`timescale 1ns/10ps
interface pmr_link_if;
   logic csN;
   logic sck;
   logic sdi;
   logic sdo;
   logic hostResetN;
   logic irq;
   logic hostClk;

   modport device (input csN, input sck, input sdi,
                   output sdo, output hostResetN, output irq, output hostClk);
   modport host   (output csN, output sck, output sdi,
                   input sdo, input hostResetN, input irq, input hostClk);
endinterface

// file: pmr_host.sv
// Host controller: APB registers drive serial frames to the transceiver.
// Assumes the link pins come from another power domain and are synchronised.
`timescale 1ns/10ps
module pmr_host
   import pmr_pkg::*;
#(
   parameter int SCK_HALF = pmr_pkg::PMR_SCK_HALF_CYC
)(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        srst,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Interrupt
   output logic             irq,
   // Link to device
   pmr_link_if.host         link
);
   import pmr_pkg::*;

   if (SCK_HALF < PMR_SCK_HALF_MIN || SCK_HALF > 65535) begin : gBadParam
      $error("SCK_HALF out of range");
   end

   typedef enum {H_IDLE, H_SHIFT, H_END} pmr_hfsm_t;

   typedef struct packed {
      pmr_hfsm_t   fsm;
      logic [15:0] cnt;
      logic [4:0]  bits;
      logic [15:0] tx;
      logic [7:0]  rx;
      logic        csN;
      logic        sck;
      logic [1:0]  sdoS;
      logic [1:0]  irqS;
      logic [1:0]  rstS;
      logic        irqPrev;
      logic        rstPrev;
      logic [2:0]  intSt;
      logic [2:0]  intMask;
      logic [31:0] rdata;
   } pmr_host_state_t;

   localparam pmr_host_state_t HOST_RESET = '{fsm: H_IDLE, csN: 1'b1, default: '0};

   pmr_host_state_t s;
   pmr_host_state_t next_s;
   logic            mapped;
   logic            wr;
   logic            busyCmd;

   assign mapped  = paddr == PMR_H_CMD_OFF || paddr == PMR_H_STAT_OFF
                    || paddr == PMR_H_INT_OFF || paddr == PMR_H_MASK_OFF;
   assign wr      = psel && penable && pwrite;
   // A frame request while one is running is refused, not queued
   assign busyCmd = pwrite && paddr == PMR_H_CMD_OFF && s.fsm != H_IDLE;

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      logic halfDone;
      halfDone = '0;
      next_s   = s;
      next_s.sdoS    = {s.sdoS[0], link.sdo};
      next_s.irqS    = {s.irqS[0], link.irq};
      next_s.rstS    = {s.rstS[0], link.hostResetN};
      next_s.irqPrev = s.irqS[1];
      next_s.rstPrev = s.rstS[1];
      halfDone       = (s.cnt == 16'(SCK_HALF - 1));
      next_s.cnt     = halfDone ? 16'h0000 : s.cnt + 16'h0001;

      if (wr && paddr == PMR_H_INT_OFF) begin
         next_s.intSt = s.intSt & ~pwdata[2:0];
      end
      if (wr && paddr == PMR_H_MASK_OFF) begin
         next_s.intMask = pwdata[2:0];
      end
      if (s.irqS[1] && !s.irqPrev) begin
         next_s.intSt[PMR_HI_DEVIRQ] = 1'b1;
      end
      if (!s.rstS[1] && s.rstPrev) begin
         next_s.intSt[PMR_HI_RSTFALL] = 1'b1;
      end

      unique case (s.fsm)
         H_IDLE: begin
            next_s.cnt = 16'h0000;
            if (wr && paddr == PMR_H_CMD_OFF) begin
               next_s.fsm  = H_SHIFT;
               next_s.tx   = pwdata[15:0];
               next_s.bits = 5'h00;
               next_s.csN  = 1'b0;
            end
         end
         H_SHIFT: begin
            if (halfDone) begin
               if (!s.sck) begin
                  next_s.sck = 1'b1;
                  next_s.rx  = {s.rx[6:0], s.sdoS[1]};
               end else begin
                  next_s.sck = 1'b0;
                  next_s.tx  = {s.tx[14:0], 1'b0};
                  if (s.bits == 5'(PMR_FRAME_BITS - 1)) begin
                     next_s.fsm = H_END;
                  end else begin
                     next_s.bits = s.bits + 5'h01;
                  end
               end
            end
         end
         H_END: begin
            if (halfDone) begin
               next_s.csN = 1'b1;
               next_s.fsm = H_IDLE;
               next_s.intSt[PMR_HI_DONE] = 1'b1;
            end
         end
      endcase

      // Read data is captured in the setup cycle and shown in the access cycle
      if (psel && !penable) begin
         unique case (paddr)
            PMR_H_STAT_OFF: next_s.rdata = {16'h0000, s.rx, 5'h00, s.irqS[1],
                                            s.rstS[1], s.fsm != H_IDLE};
            PMR_H_INT_OFF:  next_s.rdata = {29'h0, s.intSt};
            PMR_H_MASK_OFF: next_s.rdata = {29'h0, s.intMask};
            default:        next_s.rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         s <= HOST_RESET;
      end else begin
         s <= next_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   assign prdata   = s.rdata;
   assign pready   = 1'b1;
   assign pslverr  = psel && penable && (!mapped || busyCmd);
   assign irq      = |(s.intSt & s.intMask);
   assign link.csN = s.csN;
   assign link.sck = s.sck;
   assign link.sdi = s.tx[15];

endmodule // pmr_host

// file: pmr_properties.sv
// Concurrent checks on the link pins between the device and host ends.
// Assumes SCK_HALF of 8 and instantiation beside the link by the bench.
`timescale 1ns/10ps
module pmr_properties (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Link pins
   input wire logic csN,
   input wire logic sck,
   input wire logic sdi,
   input wire logic sdo,
   input wire logic hostResetN,
   input wire logic irq,
   input wire logic hostClk
);
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   logic [4:0] bits;
   // Counts clock rises within a frame, cleared between frames
   always_ff @(posedge clk) begin
      if (srst || csN) bits <= 5'h00;
      else if ($rose(sck)) bits <= bits + 5'h01;
   end
   ////////////////////////////////////////////////////////////////////////////
   link_reset_a: assert property ($fell(srst) |-> csN && !sck && !hostResetN && !hostClk
      && !irq && !sdo) else $error("link pins not idle after reset");
   clk_duty_a: assert property ($rose(hostClk) |=> !hostClk ##1 !hostClk)
      else $error("host clock high longer than one of three cycles");
   sdo_idle_a: assert property (csN |-> !sdo) else $error("sdo active outside frame");
   sck_idle_a: assert property (csN |-> !sck) else $error("sck active outside frame");
   sck_half_a: assert property ($rose(sck) |-> sck[*8] ##1 !sck)
      else $error("sck high phase not eight cycles");
   sdi_hold_a: assert property (sck |-> $stable(sdi)) else $error("sdi moved while sck high");
   frame_bits_a: assert property ($rose(csN) |-> bits == 5'h10)
      else $error("frame not sixteen bits");
   frame_start_a: assert property ($fell(csN) |-> !sck[*8] ##1 sck)
      else $error("first sck rise not eight cycles after select");
   cover property ($rose(irq));
   cover property ($rose(hostResetN));
   cover property ($rose(csN));
endmodule // pmr_properties

// file: power_mode_and_reset_control_test.sv
// Bench driving the host end over APB and the device end through its pins.
// Assumes both ends meet in pmr_link_if and the host runs with SCK_HALF of 8.
`timescale 1ns/10ps
module power_mode_and_reset_control_test;
   import pmr_pkg::*;
   logic        clk, srst, psel, penable, pwrite, pready, pslverr, irq, e;
   logic        wakePinHigh, auxSupplyDetect, supplyOutGood, supplyOutHigh, oscReady;
   logic        analogSupplyOn, coreSupplyOn, coreFromAux, supplyOutOn, coreReset, lowSupplyFlag;
   logic [4:0]  pushButtonN;
   logic [1:0]  rfOpMode;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, r;
   logic [7:0]  rb;
   pmr_mode_t   mode;
   int          mismatches, n_tests, cyc, nRst, nClk, k;
   pmr_link_if lnk();
   pmr_device pmr_device_inst (.clk, .srst, .link(lnk), .wakePinHigh, .pushButtonN,
      .auxSupplyDetect, .supplyOutGood, .supplyOutHigh, .oscReady, .mode, .analogSupplyOn,
      .coreSupplyOn, .coreFromAux, .supplyOutOn, .coreReset, .rfOpMode, .lowSupplyFlag);
   pmr_host #(.SCK_HALF(8)) pmr_host_inst (.clk, .srst, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .irq, .link(lnk));
   pmr_properties pmr_properties_inst (.clk, .srst, .csN(lnk.csN), .sck(lnk.sck),
      .sdi(lnk.sdi), .sdo(lnk.sdo), .hostResetN(lnk.hostResetN), .irq(lnk.irq),
      .hostClk(lnk.hostClk));
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   always @(posedge lnk.hostClk) nClk++;
   // A hang ends the run through the same verdict
   always @(posedge clk) begin
      cyc++;
      if (coreReset === 1'b1) nRst++;
      if (cyc == 30000) begin
         mismatches++;
         print_verdict();
      end
   end
   task automatic print_verdict();
      $display("mismatches %0d n_tests %0d", mismatches, n_tests);
      if (mismatches == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic settle();
      repeat (8) @(posedge clk);
   endtask
   // Sends one frame, then polls busy; rb keeps the byte read back
   task automatic xfer(input logic [7:0] c, input logic [7:0] d);
      int n = 0;
      apb(1'b1, PMR_H_CMD_OFF, {16'h0000, c, d});
      do begin
         apb(1'b0, PMR_H_STAT_OFF, 32'h0);
         n++;
      end while (r[PMR_HS_BUSY] !== 1'b0 && n < 500);
      rb = r[15:8];
      chk(r[PMR_HS_BUSY], 1'b0);
      settle();
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      {psel, penable, pwrite, wakePinHigh, auxSupplyDetect} = '0;
      {supplyOutGood, supplyOutHigh, oscReady, paddr, pwdata} = '0;
      {mismatches, n_tests, cyc, nRst, nClk} = '0;
      pushButtonN = 5'h1F;
      srst = 1'b1;
      repeat (10) @(posedge clk);
      srst <= 1'b0;
      {supplyOutGood, supplyOutHigh, oscReady} <= 3'h7;
      xfer({PMR_CMD_WRITE, 6'h00}, 8'hA0);
      chk(mode, PMR_OFF);
      chk(lnk.hostResetN, 1'b0);
      auxSupplyDetect <= 1'b1;
      settle();
      chk(mode, PMR_AUX);
      chk({analogSupplyOn, coreSupplyOn, coreFromAux, nRst[1:0]}, 5'h0D);
      chk(irq, 1'b0);
      apb(1'b0, PMR_H_INT_OFF, 32'h0);
      chk(r[PMR_HI_DEVIRQ], 1'b1);
      apb(1'b1, PMR_H_MASK_OFF, 32'h2);
      k = nClk;
      repeat (30) @(posedge clk);
      chk({irq, lnk.hostResetN, 6'(nClk - k)}, 8'hCA);
      xfer({PMR_CMD_RD_CTRL, 6'h00}, 8'h00);
      chk(rb, PMR_CTRL_DEFAULT[0]);
      xfer({PMR_CMD_RD_STAT, 6'h00}, 8'h00);
      chk({rb, lnk.irq}, 9'h002);
      apb(1'b1, PMR_H_INT_OFF, 32'h2);
      apb(1'b0, PMR_H_INT_OFF, 32'h0);
      chk({r[PMR_HI_DEVIRQ], irq}, 2'b00);
      xfer({PMR_CMD_WRITE, 6'h00}, 8'hA4);
      chk({mode, analogSupplyOn, coreFromAux, rfOpMode}, {PMR_IDLE, 4'hA});
      auxSupplyDetect <= 1'b0;
      xfer({PMR_CMD_OFF, 6'h00}, 8'h00);
      chk(mode, PMR_IDLE);
      xfer({PMR_CMD_WRITE, 6'h00}, 8'h80);
      for (k = 0; k < 6; k++) begin
         xfer({PMR_CMD_OFF, 6'h00}, 8'h00);
         chk(mode, PMR_OFF);
         if (k < 5) pushButtonN[k] <= 1'b0;
         else wakePinHigh <= 1'b1;
         settle();
         chk(mode, PMR_IDLE);
         xfer({PMR_CMD_RD_STAT, 6'h00}, 8'h00);
         chk(rb, (k < 5) ? 8'h08 << k : 8'h04);
         pushButtonN <= 5'h1F;
         wakePinHigh <= 1'b0;
      end
      chk(nRst, 7);
      supplyOutHigh <= 1'b0;
      settle();
      supplyOutHigh <= 1'b1;
      settle();
      chk(lowSupplyFlag, 1'b1);
      xfer({PMR_CMD_RD_STAT, 6'h00}, 8'h00);
      chk({rb, lowSupplyFlag}, 9'h004);
      xfer({PMR_CMD_WRITE, 6'h02}, 8'h01);
      chk(supplyOutOn, 1'b0);
      k = nRst;
      supplyOutGood <= 1'b0;
      settle();
      chk({lnk.hostResetN, lnk.hostClk, 8'(nRst - k)}, 10'h000);
      // Without supply a write is ignored and the host clock stays low
      k = nClk;
      xfer({PMR_CMD_WRITE, 6'h00}, 8'hA4);
      chk({mode, rfOpMode, 6'(nClk - k)}, {PMR_IDLE, 8'h00});
      supplyOutGood <= 1'b1;
      settle();
      chk(lnk.hostResetN, 1'b1);
      pushButtonN[0] <= 1'b0;
      settle();
      pushButtonN <= 5'h1F;
      chk(supplyOutOn, 1'b1);
      k = nRst;
      supplyOutGood <= 1'b0;
      settle();
      chk(nRst - k, 1);
      supplyOutGood <= 1'b1;
      apb(1'b0, 12'h010, 32'h0);
      chk(e, 1'b1);
      print_verdict();
   end
endmodule // power_mode_and_reset_control_test
